// ### hw/mwr_pkg.sv
package mwr_pkg;
  localparam int MWR_ADDR_W = 13;
  localparam int MWR_WORD_W = 32;
  localparam int MWR_WORDS = 256;
  localparam int MWR_IDX_W = 8;
  localparam int MWR_LANE_W = 5;
  localparam int MWR_RD_W = 8;
  localparam int MWR_FIFO_W = MWR_ADDR_W + MWR_WORD_W;
  localparam int MWR_FIFO_DEPTH = 32;

  // Write shape codes: port width is 2**code bits, depth 8192 >> code
  localparam logic [2:0] MWR_WS_X1 = 3'h0;
  localparam logic [2:0] MWR_WS_X2 = 3'h1;
  localparam logic [2:0] MWR_WS_X4 = 3'h2;
  localparam logic [2:0] MWR_WS_X8 = 3'h3;
  localparam logic [2:0] MWR_WS_X16 = 3'h4;
  localparam logic [2:0] MWR_WS_X32 = 3'h5;

  // Read shape codes: width 2**code bits
  localparam logic [1:0] MWR_RS_X1 = 2'h0;
  localparam logic [1:0] MWR_RS_X2 = 2'h1;
  localparam logic [1:0] MWR_RS_X4 = 2'h2;
  localparam logic [1:0] MWR_RS_X8 = 2'h3;

  localparam logic [MWR_RD_W-1:0] MWR_RD_RESET = 8'h00;

  typedef enum logic {MWR_CLK_RW, MWR_CLK_IO} mwr_clk_mode_t;
endpackage

// ### hw/mwr_fifo.sv
`timescale 1ns/10ps
module mwr_fifo
  import mwr_pkg::*;
#(
  parameter int WIDTH = MWR_FIFO_W,
  parameter int DEPTH = MWR_FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] wp_next;
  logic [AW-1:0] rp_reg;
  logic [AW-1:0] rp_next;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic ready_reg;
  logic ready_next;
  logic push;
  logic pop;

  assign in_ready = ready_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];
  assign push = in_valid & ready_reg;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Ready registered so the filling side sees a flop, at no loss of a slot
    ready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule

// ### hw/mwr_ram.sv
`timescale 1ns/10ps
module mwr_ram
  import mwr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_mode,
  input wire logic wr_ce,
  input wire logic rd_ce,
  input wire logic in_ce,
  input wire logic out_ce,
  input wire logic out_reg_en,
  input wire logic [2:0] wr_shape,
  input wire logic [1:0] rd_shape,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [MWR_ADDR_W-1:0] wr_addr,
  input wire logic [MWR_WORD_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic [MWR_ADDR_W-1:0] rd_addr,
  output logic [MWR_RD_W-1:0] rd_data,
  output logic rd_valid
);
  // Contents are not reset; a read of a location never written is undefined
  logic [MWR_WORD_W-1:0] ram [MWR_WORDS];

  logic wr_en;
  logic cap_en;
  logic oreg_en;
  logic f_valid;
  logic f_pop;
  logic [MWR_FIFO_W-1:0] f_data;
  logic [MWR_ADDR_W-1:0] f_addr;
  logic [MWR_WORD_W-1:0] f_wdata;

  logic ws_ok;
  logic [MWR_WORD_W-1:0] ws_mask;
  logic [MWR_ADDR_W-1:0] w_bit;
  logic [MWR_WORD_W-1:0] w_lane_mask;
  logic [MWR_WORD_W-1:0] w_lane_data;
  logic ram_we;
  logic [MWR_IDX_W-1:0] ram_idx;
  logic [MWR_WORD_W-1:0] ram_word_next;

  logic [MWR_RD_W-1:0] rs_mask;
  logic [MWR_ADDR_W-1:0] r_bit;
  logic [MWR_WORD_W-1:0] r_word;
  logic [MWR_WORD_W-1:0] r_shift;
  logic [MWR_RD_W-1:0] r_val;
  logic rd_take;

  logic [MWR_RD_W-1:0] hold_reg;
  logic [MWR_RD_W-1:0] hold_next;
  logic hold_vld_reg;
  logic hold_vld_next;
  logic [MWR_RD_W-1:0] rd_data_reg;
  logic [MWR_RD_W-1:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;

  // Only one real clock exists, so each port clock is modelled as an enable
  always_comb
  begin
    case (clk_mode)
      MWR_CLK_RW:
      begin
        wr_en = wr_ce;
        cap_en = rd_ce;
        oreg_en = rd_ce;
      end
      MWR_CLK_IO:
      begin
        wr_en = in_ce;
        cap_en = in_ce;
        oreg_en = out_ce;
      end
      default:
      begin
        // An unknown mode pin stalls both ports rather than guessing a clocking
        wr_en = 1'b0;
        cap_en = 1'b0;
        oreg_en = 1'b0;
      end
    endcase
  end

  // Writes queue here so the user can burst faster than the write enable drains
  // A read of a location whose write still waits here returns the old content
  mwr_fifo #(
    .WIDTH(MWR_FIFO_W),
    .DEPTH(MWR_FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_addr, wr_data}),
    .out_valid(f_valid),
    .out_ready(wr_en),
    .out_data(f_data)
  );

  assign f_addr = f_data[MWR_FIFO_W-1:MWR_WORD_W];
  assign f_wdata = f_data[MWR_WORD_W-1:0];
  assign f_pop = f_valid & wr_en;

  always_comb
  begin
    ws_ok = 1'b1;
    case (wr_shape)
      MWR_WS_X1: ws_mask = 32'h00000001;
      MWR_WS_X2: ws_mask = 32'h00000003;
      MWR_WS_X4: ws_mask = 32'h0000000f;
      MWR_WS_X8: ws_mask = 32'h000000ff;
      MWR_WS_X16: ws_mask = 32'h0000ffff;
      MWR_WS_X32: ws_mask = 32'hffffffff;
      default:
      begin
        // Unsupported shapes are drained and dropped rather than corrupting words
        ws_mask = 32'h00000000;
        ws_ok = 1'b0;
      end
    endcase
    // Upper address bits past log2(depth) fall off the shift
    w_bit = f_addr << wr_shape;
    ram_idx = w_bit[MWR_ADDR_W-1:MWR_LANE_W];
    w_lane_mask = ws_mask << w_bit[MWR_LANE_W-1:0];
    w_lane_data = (f_wdata & ws_mask) << w_bit[MWR_LANE_W-1:0];
    ram_word_next = (ram[ram_idx] & ~w_lane_mask) | w_lane_data;
    ram_we = f_pop & ws_ok;
  end

  // Whole-word read-modify-write keeps the untouched lanes of narrow writes
  always_ff @(posedge mclk)
  begin
    if (ram_we)
    begin
      ram[ram_idx] <= ram_word_next;
    end
  end

  // Narrow reads pick their lane by shifting the whole word down
  always_comb
  begin
    case (rd_shape)
      MWR_RS_X1: rs_mask = 8'h01;
      MWR_RS_X2: rs_mask = 8'h03;
      MWR_RS_X4: rs_mask = 8'h0f;
      MWR_RS_X8: rs_mask = 8'hff;
      default: rs_mask = 8'hff;
    endcase
    r_bit = rd_addr << rd_shape;
    // Same-location read alongside a write returns the old word
    r_word = ram[r_bit[MWR_ADDR_W-1:MWR_LANE_W]];
    r_shift = r_word >> r_bit[MWR_LANE_W-1:0];
    r_val = r_shift[MWR_RD_W-1:0] & rs_mask;
    rd_take = rd_req & cap_en;
  end

  // A second capture before an output step overwrites the word still held
  always_comb
  begin
    hold_next = hold_reg;
    hold_vld_next = hold_vld_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    if (out_reg_en)
    begin
      if (oreg_en & hold_vld_reg)
      begin
        rd_data_next = hold_reg;
        rd_valid_next = 1'b1;
      end
      if (rd_take)
      begin
        hold_next = r_val;
        hold_vld_next = 1'b1;
      end
      else if (oreg_en)
      begin
        hold_vld_next = 1'b0;
      end
    end
    else
    begin
      hold_vld_next = 1'b0;
      if (rd_take)
      begin
        rd_data_next = r_val;
        rd_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_reg <= MWR_RD_RESET;
      hold_vld_reg <= 1'b0;
      rd_data_reg <= MWR_RD_RESET;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      hold_vld_reg <= hold_vld_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
endmodule

// ### dv/mwr_ram_chk.sv
`timescale 1ns/10ps
module mwr_ram_chk
  import mwr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_mode,
  input wire logic rd_ce,
  input wire logic in_ce,
  input wire logic out_ce,
  input wire logic out_reg_en,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic rd_req,
  input wire logic [1:0] rd_shape,
  input wire logic [MWR_RD_W-1:0] rd_data,
  input wire logic rd_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  rd_direct_a: assert property (!clk_mode && !out_reg_en && rd_ce && rd_req |=> rd_valid)
    else $error("direct read late");
  rd_piped_a: assert property (!clk_mode && out_reg_en && rd_ce && rd_req ##1 rd_ce |=> rd_valid)
    else $error("piped read late");
  rw_idle_a: assert property (!clk_mode && !rd_ce |=> !rd_valid)
    else $error("read data without read enable");
  io_idle_a: assert property (clk_mode && !in_ce && !out_ce |=> !rd_valid)
    else $error("read data without io enable");
  io_direct_a: assert property (clk_mode && !out_reg_en && in_ce && rd_req |=> rd_valid)
    else $error("io direct read late");
  io_piped_a: assert property (clk_mode && out_reg_en && in_ce && rd_req ##1 out_ce |=> rd_valid)
    else $error("io piped read late");
  lane_zero_a: assert property (rd_valid |-> (rd_data >> (4'h1 << rd_shape)) == 8'h00)
    else $error("bits above read width set");
  cover property (rd_valid && out_reg_en);
  cover property (wr_valid && !wr_ready);
  cover property (clk_mode && rd_valid);
endmodule

bind mwr_ram mwr_ram_chk chk_i (
  .mclk(mclk),
  .arst_n(arst_n),
  .clk_mode(clk_mode),
  .rd_ce(rd_ce),
  .in_ce(in_ce),
  .out_ce(out_ce),
  .out_reg_en(out_reg_en),
  .wr_valid(wr_valid),
  .wr_ready(wr_ready),
  .rd_req(rd_req),
  .rd_shape(rd_shape),
  .rd_data(rd_data),
  .rd_valid(rd_valid)
);

// ### dv/mwr_user.sv
`timescale 1ns/10ps
module mwr_user
  import mwr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic stall,
  output logic wr_ce
);
  logic ph_reg;
  logic ph_next;
  // Slow writer: write clock only every other cycle, none while stalled
  always_comb ph_next = ~ph_reg;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) ph_reg <= 1'h0;
    else ph_reg <= ph_next;
  assign wr_ce = !stall && ph_reg;
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
module tb
  import mwr_pkg::*;
;
  logic mclk = 0, arst_n = 0, clk_mode = 0, out_reg_en = 0, cap = 0, outp = 0;
  logic stall = 1, wr_valid = 0, rd_req = 0, wr_ready, rd_valid, wr_ce, rd_ce, in_ce, out_ce;
  logic [2:0] wr_shape = 3'h5;
  logic [1:0] rd_shape = 2'h0;
  logic [12:0] wr_addr = 13'h0, rd_addr = 13'h0;
  logic [31:0] wr_data = 32'h0;
  logic [7:0] rd_data;
  logic [8191:0] m;
  int err_total = 0, tests_run = 0, cyc = 0;
  assign rd_ce = !clk_mode & (cap | outp);
  assign in_ce = clk_mode & cap;
  assign out_ce = clk_mode & outp;
  mwr_ram uut (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_mode(clk_mode),
    .wr_ce(wr_ce),
    .rd_ce(rd_ce),
    .in_ce(in_ce),
    .out_ce(out_ce),
    .out_reg_en(out_reg_en),
    .wr_shape(wr_shape),
    .rd_shape(rd_shape),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );
  mwr_user user_i (.mclk(mclk), .arst_n(arst_n), .stall(stall), .wr_ce(wr_ce));
  initial forever #10 mclk = ~mclk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk)
    if (++cyc == 5000)
    begin
      err_total++;
      wrap_up();
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Leaves wr_valid up so back-to-back writes need no idle cycle
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    for (int i = 0; i < (1 << wr_shape); i++) m[(a << wr_shape) + i] = d[i];
    wr_valid <= 1'h1;
    wr_addr <= a;
    wr_data <= d;
    do @(negedge mclk); while (wr_ready !== 1'h1);
    @(posedge mclk);
  endtask
  task automatic rd(input logic [12:0] a);
    logic [7:0] e;
    for (int i = 0; i < 8; i++) e[i] = (i < (1 << rd_shape)) ? m[(a << rd_shape) + i] : 1'h0;
    rd_req <= 1'h1;
    rd_addr <= a;
    cap <= 1'h1;
    @(posedge mclk);
    rd_req <= 1'h0;
    cap <= 1'h0;
    if (out_reg_en)
    begin
      outp <= 1'h1;
      @(posedge mclk);
      outp <= 1'h0;
    end
    @(negedge mclk);
    chk(rd_valid, 1);
    chk(rd_data, e);
    @(posedge mclk);
  endtask
  task automatic t_fill;
    for (int i = 0; i < 32; i++) wr(13'(i), 32'h9e3779b9 * (i + 1));
    wr_valid <= 1'h0;
    repeat (2) @(negedge mclk);
    chk(wr_ready, 0);
    @(posedge mclk);
    stall <= 1'h0;
    repeat (80) @(posedge mclk);
    @(negedge mclk);
    chk(wr_ready, 1);
    @(posedge mclk);
  endtask
  task automatic t_shapes;
    for (int s = 0; s < 4; s++)
    begin
      rd_shape <= 2'(s);
      @(posedge mclk);
      for (int j = 0; j < 4; j++) rd(13'((j * 37 + s) % (1024 >> s)));
    end
  endtask
  task automatic t_modes;
    for (int k = 0; k < 3; k++)
    begin
      clk_mode <= (k != 0);
      out_reg_en <= (k != 1);
      @(posedge mclk);
      rd(13'h5);
      rd(13'h1a);
    end
    clk_mode <= 1'h0;
    out_reg_en <= 1'h0;
  endtask
  task automatic t_narrow;
    for (int s = 0; s < 5; s++)
    begin
      wr_shape <= 3'(s);
      @(posedge mclk);
      wr(13'((((s + 1) * 32) >> s) + 1), 32'hc3a55a3c ^ s);
      wr_valid <= 1'h0;
      rd(13'h2);
      repeat (3) @(posedge mclk);
      rd(13'((((s + 1) * 32) + (1 << s)) >> 3));
    end
  endtask
  // Mid-run reset: outputs clear, queue empties, memory keeps its words
  task automatic t_reset;
    arst_n <= 1'h0;
    @(negedge mclk);
    chk(wr_ready, 0);
    chk(rd_valid, 0);
    chk(rd_data, MWR_RD_RESET);
    @(posedge mclk);
    arst_n <= 1'h1;
    @(negedge mclk);
    chk(wr_ready, 0);
    @(negedge mclk);
    chk(wr_ready, 1);
    @(posedge mclk);
    rd(13'h5);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    t_fill();
    t_shapes();
    t_modes();
    t_narrow();
    t_reset();
    wrap_up();
  end
endmodule
